/* inc/sss_pkg.sv */
// shared constants and types of the soft-start initialisation sequencer
package sss_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_NS      = 10;       // sys_clk period
    localparam int SW_PERIOD_NS    = 1428;     // switching period at 700 kHz
    localparam int PHASE_DIV_CYC   = SW_PERIOD_NS / SYS_CLK_NS;
    localparam int GATE_OFF_MAX_NS = 100;      // longest gate turn-off latency
    localparam int GATE_OFF_CYC    = GATE_OFF_MAX_NS / SYS_CLK_NS;
    localparam int START_DELAY_CYC = 384;      // phase pulses before soft-start
    localparam int SS_RAMP_CYC     = 2560;     // phase pulses for 0 V to 0.6 V
    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int DIV_W           = 8;
    localparam int DLY_W           = 9;
    localparam int SS_W            = 12;
    localparam logic RST_LOW       = 1'b0;
    localparam logic RST_HIGH      = 1'b1;
    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_DELAY,
        SQ_SOFT,
        SQ_RUN
    } sss_state_t;
endpackage : sss_pkg

/* core/sss_phase_div.sv */
// phase clock divider: one-cycle enable pulse per switching period
`timescale 1ns/1ps
module sss_phase_div
    import sss_pkg::*;
#(
    parameter int DIV = PHASE_DIV_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // control
    input  wire logic run,
    // phase pulse
    output logic      phase_pulse
);
    logic [DIV_W-1:0] cnt_q;

    // --------------------------------------------------------------------
    // divider
    // --------------------------------------------------------------------
    // restarts from zero whenever run drops so every start attempt is aligned
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (!run || cnt_q == DIV_W'(DIV - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + DIV_W'(1);
        end
    end

    // pulse on the last count of each period
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_pulse <= RST_LOW;
        end else begin
            phase_pulse <= run && cnt_q == DIV_W'(DIV - 2);
        end
    end
endmodule : sss_phase_div

/* core/sss_sequencer.sv */
// soft-start initialisation sequencer with pre-charge and overvoltage handling
// Operation
// RL1 - supply and enable drop resets sequencer anytime
// RL2 - soft-start 384 cycles after all ready
// RL3 - enable sink on until system enabled
// RL4 - fault clears soft-start, gates off quickly
// RL5 - ramp counter steps per phase, 2560 total
// RL6 - gates withheld until first pwm pulse
// RL7 - low side off first switching cycle
// RL8 - prebias above target waits for reference
// RL9 - 113 to 120 percent: hiccup low side
// RL10 - above 120 percent latches off
// RL11 - latch clears only on bias removal
// RL12 - counters restart from zero each attempt
`timescale 1ns/1ps
module sss_sequencer
    import sss_pkg::*;
(
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    // start qualifiers
    input  wire logic            en_above_th,
    input  wire logic            vcc_por_ok,
    input  wire logic            driver_bias_supply_por_ok,
    input  wire logic            pll_locked,
    // modulator and output comparators
    input  wire logic            pwm_in,
    input  wire logic            vout_above_target,
    input  wire logic            ref_reached_vout,
    input  wire logic            vout_above_113,
    input  wire logic            vout_above_120,
    input  wire logic            vout_below_87,
    // gate drives
    output logic                 high_side_gate_drive,
    output logic                 low_side_gate_drive,
    // enable pin control
    output logic                 enable_sink_on,
    output logic                 enable_pull_low,
    // status
    output logic [SS_W-1:0]      soft_start_level,
    output logic                 soft_start_done,
    output logic                 latched_off
);
    // --------------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------------
    sss_state_t       state_q;
    logic [DLY_W-1:0] dly_cnt_q;
    logic [SS_W-1:0]  ss_cnt_q;
    logic             phase_pulse;
    logic             ready;
    logic             released_q;
    logic             prebias_hold_q;
    logic             first_cyc_q;
    logic             ls_sink_q;
    logic             sink_spent_q;
    logic             release_now;
    logic             ramping;

    // all start conditions; any drop is a reset of the sequence
    assign ready = en_above_th && vcc_por_ok && driver_bias_supply_por_ok
                   && pll_locked && !latched_off && !ls_sink_q;   // RL1
    assign ramping = state_q == SQ_SOFT || state_q == SQ_RUN;
    assign release_now = ready && ramping && !released_q && !prebias_hold_q && pwm_in;

    sss_phase_div #(
        .DIV         (PHASE_DIV_CYC)
    ) u_div (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .run         (ready),
        .phase_pulse (phase_pulse)
    );

    // --------------------------------------------------------------------
    // sequence state
    // --------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SQ_IDLE;
        end else if (!ready) begin
            state_q <= SQ_IDLE;                                   // RL1
        end else begin
            case (state_q)
                SQ_IDLE: state_q <= SQ_DELAY;
                SQ_DELAY: begin
                    if (phase_pulse && dly_cnt_q == DLY_W'(START_DELAY_CYC - 1)) begin
                        state_q <= SQ_SOFT;                       // RL2
                    end
                end
                SQ_SOFT: begin
                    if (phase_pulse && ss_cnt_q == SS_W'(SS_RAMP_CYC - 1)) begin
                        state_q <= SQ_RUN;
                    end
                end
                SQ_RUN: state_q <= SQ_RUN;
                default: state_q <= SQ_IDLE;
            endcase
        end
    end

    // start delay counter, cleared outside the delay phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dly_cnt_q <= '0;
        end else if (!ready || state_q != SQ_DELAY) begin
            dly_cnt_q <= '0;                                      // RL12
        end else if (phase_pulse) begin
            dly_cnt_q <= dly_cnt_q + DLY_W'(1);                   // RL2
        end
    end

    // soft-start ramp counter doubles as the reference level
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ss_cnt_q <= '0;
        end else if (!ready) begin
            ss_cnt_q <= '0;                                       // RL4 RL12
        end else if (state_q == SQ_SOFT && phase_pulse) begin
            ss_cnt_q <= ss_cnt_q + SS_W'(1);                      // RL5
        end
    end

    // --------------------------------------------------------------------
    // pre-charged output handling
    // --------------------------------------------------------------------
    // sampled during the delay so a prebias is known before the ramp starts
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prebias_hold_q <= RST_LOW;
        end else if (!ready) begin
            prebias_hold_q <= RST_LOW;
        end else if (state_q == SQ_DELAY) begin
            prebias_hold_q <= vout_above_target;                  // RL8
        end else if (ref_reached_vout) begin
            prebias_hold_q <= RST_LOW;                            // RL8
        end
    end

    // drivers see pwm only after the first pulse during the ramp
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            released_q <= RST_LOW;
        end else if (!ready) begin
            released_q <= RST_LOW;
        end else if (release_now) begin
            released_q <= RST_HIGH;                               // RL6
        end
    end

    // bootstrap charge window: first switching period after release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            first_cyc_q <= RST_LOW;
        end else if (!ready) begin
            first_cyc_q <= RST_LOW;
        end else if (release_now) begin
            first_cyc_q <= RST_HIGH;                              // RL7
        end else if (phase_pulse) begin
            first_cyc_q <= RST_LOW;
        end
    end

    // --------------------------------------------------------------------
    // overvoltage protection
    // --------------------------------------------------------------------
    // latch survives enable toggles; only loss of control bias clears it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            latched_off <= RST_LOW;
        end else if (!vcc_por_ok) begin
            latched_off <= RST_LOW;                               // RL11
        end else if (vout_above_120) begin
            latched_off <= RST_HIGH;                              // RL10
        end
    end

    // once latched, the low side sinks only until the first fall below 87 percent
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sink_spent_q <= RST_LOW;
        end else if (!vcc_por_ok) begin
            sink_spent_q <= RST_LOW;
        end else if (latched_off && vout_below_87) begin
            sink_spent_q <= RST_HIGH;                             // RL10
        end
    end

    // low-side sink hysteresis; set wins over the release threshold
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ls_sink_q <= RST_LOW;
        end else if (vout_above_113 && !sink_spent_q) begin
            ls_sink_q <= RST_HIGH;                                // RL9
        end else if (vout_below_87 || sink_spent_q) begin
            ls_sink_q <= RST_LOW;                                 // RL9
        end
    end

    // --------------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------------
    // gates follow pwm and the qualifiers by one edge, the overvoltage comparators by two, well inside the 100 ns limit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            high_side_gate_drive <= RST_LOW;
            low_side_gate_drive  <= RST_LOW;
        end else begin
            high_side_gate_drive <= ready && released_q && pwm_in;            // RL4 RL6
            low_side_gate_drive  <= (ready && released_q && !pwm_in
                                     && !first_cyc_q) || ls_sink_q;         // RL7 RL9
        end
    end

    // enable pin controls and status
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable_sink_on   <= RST_HIGH;
            enable_pull_low  <= RST_LOW;
            soft_start_level <= '0;
            soft_start_done  <= RST_LOW;
        end else begin
            enable_sink_on   <= !ready;                           // RL3
            enable_pull_low  <= ls_sink_q || latched_off;         // RL9 RL10
            soft_start_level <= ss_cnt_q;
            soft_start_done  <= ready && state_q == SQ_RUN;
        end
    end

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence sink_then_drive_s;
        ls_sink_q ##1 low_side_gate_drive && enable_pull_low;
    endsequence

    sequence delay_done_s;
        state_q == SQ_DELAY && phase_pulse && dly_cnt_q == DLY_W'(START_DELAY_CYC - 1);
    endsequence

    drop_resets_a: assert property (!ready |=> state_q == SQ_IDLE && ss_cnt_q == '0) // RL1
        else $error("sequencer not reset after qualifier drop");
    start_delay_a: assert property ($rose(state_q == SQ_SOFT) |-> // RL2
        $past(state_q == SQ_DELAY && phase_pulse && dly_cnt_q == DLY_W'(START_DELAY_CYC - 1)))
        else $error("soft-start entered without full start delay");
    delay_exit_a: assert property (delay_done_s ##0 ready |=> state_q == SQ_SOFT) // RL2
        else $error("soft-start not entered after full start delay");
    enable_sink_a: assert property (ready |=> // RL3
        !enable_sink_on ##0 $past(ready) != enable_sink_on)
        else $error("enable sink not following enabled state");
    gates_off_a: assert property (!ready && !ls_sink_q |=> // RL4
        !high_side_gate_drive && !low_side_gate_drive)
        else $error("gate drive not off after fault");
    ramp_length_a: assert property ($rose(state_q == SQ_RUN) |-> // RL5
        ss_cnt_q == SS_W'(SS_RAMP_CYC))
        else $error("soft-start ramp length wrong");
    // judged on the edge that moved the count, so a restart to zero is not a step
    ramp_step_a: assert property (ss_cnt_q != $past(ss_cnt_q) && $past(ready) |-> // RL5
        $past(phase_pulse))
        else $error("ramp advanced without phase pulse");
    pwm_withheld_a: assert property (!released_q |=> !high_side_gate_drive) // RL6
        else $error("high side driven before first pwm pulse");
    boot_charge_a: assert property (first_cyc_q && !ls_sink_q |=> !low_side_gate_drive) // RL7
        else $error("low side driven in bootstrap cycle");
    prebias_wait_a: assert property (prebias_hold_q |-> !released_q) // RL8
        else $error("switching released while prebias hold active");
    ov_hiccup_a: assert property (vout_above_113 && !sink_spent_q |=> sink_then_drive_s) // RL9
        else $error("low-side sink not engaged above 113 percent");
    ov_latch_a: assert property (vout_above_120 && vcc_por_ok |=> // RL10
        latched_off ##1 state_q == SQ_IDLE)
        else $error("overvoltage latch-off not taken");
    latch_hold_a: assert property (latched_off && vcc_por_ok |=> latched_off) // RL11
        else $error("latch cleared while control bias present");
    restart_zero_a: assert property ($rose(state_q == SQ_DELAY) |-> // RL12
        dly_cnt_q == '0 && ss_cnt_q == '0)
        else $error("counters not restarted from zero");
endmodule : sss_sequencer

/* dv/sss_drv_model.sv */
// far-side model: gate drivers and the shared enable line of paralleled modules
`timescale 1ns/1ps
module sss_drv_model (
    // clock
    input  wire logic sys_clk,
    // gate drives from the sequencer
    input  wire logic high_side_gate_drive,
    input  wire logic low_side_gate_drive,
    // enable line
    input  wire logic en_drive,
    input  wire logic enable_pull_low,
    output logic      en_above_th,
    // driver health
    output logic      shoot_seen
);
    // the pull-down of any module drags the tied enable line low for all of them
    assign en_above_th = en_drive & ~enable_pull_low;

    // both switches on at once would short the input rail; remember it forever
    initial shoot_seen = 1'b0;
    always @(posedge sys_clk) begin
        if (high_side_gate_drive && low_side_gate_drive) begin
            shoot_seen <= 1'b1;
        end
    end
endmodule : sss_drv_model

/* dv/tb.sv */
// self-checking bench for the soft-start initialisation sequencer
`timescale 1ns/1ps
module tb;
    import sss_pkg::*;
    // ------------------------------------------------------------------
    // signals and table of ordinary cases
    // ------------------------------------------------------------------
    logic            sys_clk, rstn, en_drive, en_above_th, shoot_seen;
    logic            vcc_por_ok, driver_bias_supply_por_ok, pll_locked, pwm_in;
    logic            vout_above_target, ref_reached_vout;
    logic            vout_above_113, vout_above_120, vout_below_87;
    logic            high_side_gate_drive, low_side_gate_drive;
    logic            enable_sink_on, enable_pull_low, soft_start_done, latched_off;
    logic [SS_W-1:0] soft_start_level;
    int              checked, miscompares, n;
    localparam int   EXP_FIRST = (START_DELAY_CYC + 1) * PHASE_DIV_CYC + 1;
    typedef struct packed {
        logic [3:0] qual;   // enable, control bias, driver bias, lock
        logic [8:0] hold;   // cycles before looking
        logic       sink;   // expected enable sink
    } sss_row_t;
    localparam sss_row_t ROWS [7] = '{
        '{4'hf, 9'h12c, 1'h0}, '{4'h7, 9'h005, 1'h1}, '{4'hf, 9'h12c, 1'h0},
        '{4'hb, 9'h005, 1'h1}, '{4'hd, 9'h005, 1'h1}, '{4'he, 9'h005, 1'h1},
        '{4'h0, 9'h005, 1'h1}};

    sss_sequencer u_sss_sequencer (
        .sys_clk(sys_clk), .rstn(rstn), .en_above_th(en_above_th),
        .vcc_por_ok(vcc_por_ok), .driver_bias_supply_por_ok(driver_bias_supply_por_ok),
        .pll_locked(pll_locked), .pwm_in(pwm_in), .vout_above_target(vout_above_target),
        .ref_reached_vout(ref_reached_vout), .vout_above_113(vout_above_113),
        .vout_above_120(vout_above_120), .vout_below_87(vout_below_87),
        .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive),
        .enable_sink_on(enable_sink_on), .enable_pull_low(enable_pull_low),
        .soft_start_level(soft_start_level), .soft_start_done(soft_start_done),
        .latched_off(latched_off));
    sss_drv_model u_sss_drv_model (
        .sys_clk(sys_clk), .high_side_gate_drive(high_side_gate_drive),
        .low_side_gate_drive(low_side_gate_drive), .en_drive(en_drive),
        .enable_pull_low(enable_pull_low), .en_above_th(en_above_th), .shoot_seen(shoot_seen));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // inputs move only right after a rising edge; outputs are read mid-cycle
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : tick
    task automatic mid;
        @(negedge sys_clk);
    endtask : mid
    task automatic chk(input logic [SS_W-1:0] seen, input logic [SS_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    // bounded wait for a ramp step, counting edges so spacing can be judged;
    // the level is read mid-cycle and the task returns mid-cycle
    task automatic wait_level(input logic [SS_W-1:0] lvl);
        n = 0;
        while (soft_start_level !== lvl && n < 60000) begin
            tick(1);
            mid;
            n++;
        end
    endtask : wait_level
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // the whole run is about 56k cycles, so 80k means a hang
    initial begin
        #(80000 * 10);
        miscompares++;
        $display("ERROR %0t: run did not finish", $time);
        close_out();
    end
    initial begin
        checked = 0;
        miscompares = 0;
        {rstn, en_drive, vcc_por_ok, driver_bias_supply_por_ok, pll_locked} = 5'h00;
        {pwm_in, vout_above_target, ref_reached_vout} = 3'h0;
        {vout_above_113, vout_above_120, vout_below_87} = 3'h0;
        tick(10);
        mid;
        chk(enable_sink_on, 1'h1);
        chk({high_side_gate_drive, low_side_gate_drive, latched_off}, 3'h0);
        tick(1);
        rstn <= 1'b1;
        // each qualifier dropped alone, then all at once; 300-cycle ready spans come before the first two drops
        foreach (ROWS[i]) begin
            {en_drive, vcc_por_ok, driver_bias_supply_por_ok, pll_locked} <= ROWS[i].qual;
            tick(ROWS[i].hold);
            mid;
            chk(enable_sink_on, ROWS[i].sink);
            chk(soft_start_level, 12'h000);
            chk(high_side_gate_drive | low_side_gate_drive, 1'h0);
            tick(1);
        end
        // full start into an output already above target
        vout_above_target <= 1'b1;
        {en_drive, vcc_por_ok, driver_bias_supply_por_ok, pll_locked} <= 4'hf;
        wait_level(12'h001);
        chk(n >= EXP_FIRST - 4 && n <= EXP_FIRST + 4, 1'h1);
        chk(enable_sink_on, 1'h0);
        wait_level(12'h002);
        chk(n == PHASE_DIV_CYC, 1'h1);
        tick(1);
        pwm_in <= 1'b1;
        tick(20);
        mid;
        chk(high_side_gate_drive | low_side_gate_drive, 1'h0);
        tick(1);
        pwm_in <= 1'b0;
        ref_reached_vout <= 1'b1;
        tick(10);
        mid;
        chk(low_side_gate_drive, 1'h0);
        tick(1);
        pwm_in <= 1'b1;
        tick(3);
        mid;
        chk(high_side_gate_drive, 1'h1);
        tick(1);
        pwm_in <= 1'b0;
        tick(3);
        mid;
        chk({high_side_gate_drive, low_side_gate_drive}, 2'h0);
        wait_level(12'h003);
        tick(3);
        mid;
        chk(low_side_gate_drive, 1'h1);
        tick(1);
        // bias loss in mid-ramp
        vcc_por_ok <= 1'b0;
        tick(3);
        mid;
        chk({high_side_gate_drive, low_side_gate_drive, soft_start_done}, 3'h0);
        chk(soft_start_level, 12'h000);
        tick(1);
        // non-latching overvoltage hiccup with the enable held low
        {en_drive, vcc_por_ok, vout_above_113} <= 3'h3;
        tick(3);
        mid;
        chk({low_side_gate_drive, enable_pull_low, high_side_gate_drive}, 3'h6);
        tick(1);
        {vout_above_113, vout_below_87} <= 2'h1;
        tick(3);
        mid;
        chk({low_side_gate_drive, enable_pull_low}, 2'h0);
        tick(1);
        // latching overvoltage, then an enable toggle that must not clear it
        {vout_below_87, vout_above_120} <= 2'h1;
        tick(3);
        mid;
        chk({latched_off, enable_pull_low, high_side_gate_drive}, 3'h6);
        tick(1);
        {vout_above_120, en_drive} <= 2'h1;
        tick(5);
        en_drive <= 1'b0;
        tick(5);
        en_drive <= 1'b1;
        tick(300);
        mid;
        chk({latched_off, enable_sink_on, high_side_gate_drive}, 3'h6);
        tick(1);
        vcc_por_ok <= 1'b0;
        tick(3);
        mid;
        chk(latched_off, 1'h0);
        chk(shoot_seen, 1'h0);
        // second reset in the middle of a start delay, then a clean restart
        tick(1);
        vcc_por_ok <= 1'b1;
        tick(300);
        rstn <= 1'b0;
        tick(2);
        mid;
        chk({enable_sink_on, high_side_gate_drive, low_side_gate_drive}, 3'h4);
        tick(1);
        rstn <= 1'b1;
        tick(3);
        mid;
        chk(enable_sink_on, 1'h0);
        chk(soft_start_level, 12'h000);
        close_out();
    end
endmodule : tb
